// [bench/mieu_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mieu_mem_model (
    input wire logic i_core_clk, // system clock
    input wire logic [7:0] i_addr, // read address
    input wire logic i_we, // write pulse
    input wire logic [7:0] i_waddr, // write address
    input wire logic [7:0] i_wdata, // write data
    output logic [7:0] o_rdata // combinational read data
);
    logic [7:0] mem [256];
    assign o_rdata = mem[i_addr];
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
endmodule : mieu_mem_model
`default_nettype wire

// [bench/test_mcu_instruction_execution_unit.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
    mismatches++; $display("Error %s expected %h seen %h", n, e, s); end end
module test_mcu_instruction_execution_unit;
    localparam logic [7:0] ADR = 8'h20;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_issue = 1'b0;
    mieu_pkg::mieu_instr_s i_instr = '0;
    logic [7:0] rdata, acc, table_high_byte, wdata, addr, a;
    logic ready, we, pd, skip;
    logic [2:0] cycles;
    mieu_pkg::mieu_flags_s flags, f;
    int mismatches = 0;
    int num_checks = 0;
    int ticks = 0;
    mieu_pkg::mieu_op_e br [4];
    mieu_mem_model u_mem (.i_core_clk(i_core_clk), .i_addr(i_instr.mem),
        .i_we(we), .i_waddr(addr), .i_wdata(wdata), .o_rdata(rdata));
    mieu_core u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_issue(i_issue), .i_instr(i_instr), .i_mem_rdata(rdata),
        .o_ready(ready), .o_mem_we(we), .o_mem_addr(addr),
        .o_mem_wdata(wdata), .o_acc(acc), .o_table_high_byte(table_high_byte),
        .o_flags(flags), .o_power_down(pd), .o_skip(skip),
        .o_cycles(cycles));
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        ticks <= ticks + 1;
        if (ticks == 2000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////
    // ctl = {bit index, pcl target, pair done}; e = {cycles, write, skip}
    task automatic op(input mieu_pkg::mieu_op_e o, input logic [7:0] d, x,
        input logic [4:0] ctl, e, input logic [7:0] wd);
        int n;
        u_mem.mem[ADR] = d;
        @(posedge i_core_clk);
        i_issue <= 1'b1;
        i_instr <= '{o, ADR, x, ctl[4:2], ctl[1], ctl[0], {x, ~x}};
        @(posedge i_core_clk);
        i_issue <= 1'b0;
        #1;
        `CHK("acc", a, acc)
        `CHK("flags", f, flags)
        `CHK("cycles", e[4:2], cycles)
        `CHK("mem_we", e[1], we)
        `CHK("skip", e[0], skip)
        if (e[1]) begin
            `CHK("wdata", wd, wdata)
            `CHK("addr", ADR, addr)
        end
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge i_core_clk);
            #1;
        end
        `CHK("busy", 4 * e[4:2], n)
    endtask : op
    ////////////////////////////////////////////////////////////////////
    initial begin
        br = '{mieu_pkg::OP_JMP, mieu_pkg::OP_CALL, mieu_pkg::OP_RET,
            mieu_pkg::OP_INTERRUPT_RETURN};
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        #1;
        `CHK("rst_flags", mieu_pkg::RST_FLAGS, flags)
        `CHK("rst_acc", mieu_pkg::RST_ACC, acc)
        `CHK("rst_table_high_byte", mieu_pkg::RST_TABLE_HIGH_BYTE, table_high_byte)
        `CHK("rst_ready", 1'b1, ready)
        a = 8'h3C;
        f = mieu_pkg::RST_FLAGS;
        op(mieu_pkg::OP_MOVI, 8'h00, 8'h3C, 5'h00, 5'h04, 8'h00);
        a = 8'h00;
        f = 6'h07;
        op(mieu_pkg::OP_ADD, 8'hC4, 8'h00, 5'h00, 5'h04, 8'h00);
        a = 8'h80;
        f = 6'h0A;
        op(mieu_pkg::OP_ADC, 8'h7F, 8'h00, 5'h00, 5'h04, 8'h00);
        f = 6'h00;
        op(mieu_pkg::OP_SUM_TO_MEMORY, 8'h01, 8'h00, 5'h02, 5'h0A, 8'h81);
        a = 8'hA0;
        op(mieu_pkg::OP_MOVI, 8'h00, 8'hA0, 5'h00, 5'h04, 8'h00);
        f = 6'h01;
        op(mieu_pkg::OP_DAA, 8'h00, 8'h00, 5'h00, 5'h06, 8'h00);
        a = 8'h90;
        f = 6'h03;
        op(mieu_pkg::OP_SUB, 8'h10, 8'h00, 5'h00, 5'h04, 8'h00);
        f.signed_result_flag = 1'b1;
        op(mieu_pkg::OP_SBCM, 8'h20, 8'h00, 5'h00, 5'h06, 8'h70);
        a = 8'h00;
        f.zero_flag = 1'b1;
        op(mieu_pkg::OP_ANDI, 8'h00, 8'h00, 5'h00, 5'h04, 8'h00);
        a = 8'h0F;
        f.zero_flag = 1'b0;
        op(mieu_pkg::OP_CPLA, 8'hF0, 8'h00, 5'h00, 5'h04, 8'h00);
        a = 8'h80;
        op(mieu_pkg::OP_RRA, 8'h01, 8'h00, 5'h00, 5'h04, 8'h00);
        a = 8'h81;
        f.carry_flag = 1'b0;
        op(mieu_pkg::OP_RRCA, 8'h02, 8'h00, 5'h00, 5'h04, 8'h00);
        op(mieu_pkg::OP_SZ, 8'h00, 8'h00, 5'h00, 5'h09, 8'h00);
        op(mieu_pkg::OP_SZ, 8'h01, 8'h00, 5'h00, 5'h04, 8'h00);
        op(mieu_pkg::OP_SZB, 8'h7F, 8'h00, 5'h1C, 5'h09, 8'h00);
        op(mieu_pkg::OP_SNZB, 8'h7F, 8'h00, 5'h00, 5'h09, 8'h00);
        op(mieu_pkg::OP_SZB, 8'h7F, 8'h00, 5'h00, 5'h04, 8'h00);
        op(mieu_pkg::OP_SDZ, 8'h01, 8'h00, 5'h02, 5'h0F, 8'h00);
        a = 8'h00;
        op(mieu_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR, 8'h01, 8'h00, 5'h02, 5'h09, 8'h00);
        foreach (br[i]) begin
            op(br[i], 8'h00, 8'h00, 5'h00, 5'h08, 8'h00);
        end
        a = 8'h55;
        op(mieu_pkg::OP_RETA, 8'h00, 8'h55, 5'h00, 5'h08, 8'h00);
        op(mieu_pkg::OP_TRDC, 8'h00, 8'hA5, 5'h00, 5'h0A, 8'h5A);
        `CHK("table_high_byte", 8'hA5, table_high_byte)
        op(mieu_pkg::OP_TRDL, 8'h00, 8'h3C, 5'h00, 5'h0A, 8'hC3);
        `CHK("table_high_byte", 8'h3C, table_high_byte)
        op(mieu_pkg::OP_BSET, 8'h00, 8'h00, 5'h1C, 5'h06, 8'h80);
        op(mieu_pkg::OP_BCLR, 8'hFF, 8'h00, 5'h00, 5'h06, 8'hFE);
        a = 8'h21;
        op(mieu_pkg::OP_SWAPA, 8'h12, 8'h00, 5'h00, 5'h04, 8'h00);
        f.power_down_flag = 1'b1;
        f.watchdog_expiry_flag = 1'b0;
        op(mieu_pkg::OP_HALT, 8'h00, 8'h00, 5'h00, 5'h04, 8'h00);
        `CHK("power_down", 1'b1, pd)
        op(mieu_pkg::OP_WDTP1, 8'h00, 8'h00, 5'h00, 5'h04, 8'h00);
        f.power_down_flag = 1'b0;
        op(mieu_pkg::OP_WDTP2, 8'h00, 8'h00, 5'h01, 5'h04, 8'h00);
        wrap_up();
    end
endmodule : test_mcu_instruction_execution_unit
`default_nettype wire

// [hw/mieu_core.sv]
// Contract
// [RQ1] writing program counter low byte adds one four-clock cycle
// [RQ2] a taken skip adds one cycle; no skip keeps base count
// [RQ3] memory-writing increment/decrement skips take both penalties
// [RQ4] preclear pair clears expiry and power-down only when watchdog cleared
// [RQ5] jump, call, returns take two cycles and touch no flag
// [RQ6] table reads load memory byte plus table-high byte, two cycles
// [RQ7] add-with-carry sums memory, accumulator and carry
// [RQ8] plain add stores sum in accumulator, updates four flags
// [RQ9] add and subtract forms take one cycle, update Z C AC OV
// [RQ10] subtract-with-carry subtracts memory and borrow, memory variant exists
// [RQ11] decimal adjust corrects accumulator into memory, only carry changes
// [RQ12] logic ops and complements take one cycle, only zero changes
// [RQ13] complement variant writes inverted value to accumulator
// [RQ14] plain rotates change no flag; through-carry rotates update carry
// [RQ15] moves and immediate load take one cycle, no flag
// [RQ16] bit set/clear address bit 0..7, no flag changes
// [RQ17] bit-test skips on zero, inverse on nonzero, no flag
// [RQ18] accumulator-result skip variants take only skip penalty
// [RQ19] nibble swap exchanges halves, accumulator variant, no flag
// [RQ20] halt enters power-down within one cycle, updates watchdog flags
// [RQ21] unaffected instructions keep every status flag
`timescale 1ns/1ns
`default_nettype none
module mieu_core (
    input wire logic i_core_clk, // 20 MHz system clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_issue, // instruction offered (pulse)
    input wire mieu_pkg::mieu_instr_s i_instr, // decoded instruction
    input wire logic [7:0] i_mem_rdata, // addressed data memory byte
    output logic o_ready, // core accepts an issue
    output logic o_mem_we, // data memory write pulse
    output logic [7:0] o_mem_addr, // data memory address
    output logic [7:0] o_mem_wdata, // data memory write data
    output logic [7:0] o_acc, // accumulator
    output logic [7:0] o_table_high_byte, // table-high byte
    output mieu_pkg::mieu_flags_s o_flags, // status flags
    output logic o_power_down, // power-down mode
    output logic o_skip, // next instruction skipped (pulse)
    output logic [2:0] o_cycles // instruction cycles of last op
);
    typedef struct packed {
        mieu_pkg::mieu_state_e st;
        logic [1:0] phase;
        logic [1:0] left;
        logic [2:0] cycles;
        logic [7:0] acc;
        logic [7:0] table_high_byte;
        mieu_pkg::mieu_flags_s fl;
        logic pd;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic skip;
    } mieu_state_s;

    mieu_state_s s_q;
    mieu_state_s s_d;

    function automatic logic is_mem_dest(input mieu_pkg::mieu_op_e op);
        case (op)
            mieu_pkg::OP_SUM_TO_MEMORY, mieu_pkg::OP_SUM_WITH_CARRY_TO_MEMORY, mieu_pkg::OP_SUBM,
            mieu_pkg::OP_SBCM, mieu_pkg::OP_DAA, mieu_pkg::OP_ANDM,
            mieu_pkg::OP_ORM, mieu_pkg::OP_XORM, mieu_pkg::OP_CPL,
            mieu_pkg::OP_INC, mieu_pkg::OP_DEC, mieu_pkg::OP_RR,
            mieu_pkg::OP_RRC, mieu_pkg::OP_RL, mieu_pkg::OP_RLC,
            mieu_pkg::OP_MOVM, mieu_pkg::OP_BCLR, mieu_pkg::OP_BSET,
            mieu_pkg::OP_SIZ, mieu_pkg::OP_SDZ, mieu_pkg::OP_TRDC,
            mieu_pkg::OP_TRDL, mieu_pkg::OP_CLRM, mieu_pkg::OP_SETM,
            mieu_pkg::OP_SWAP: is_mem_dest = 1'b1;
            default: is_mem_dest = 1'b0;
        endcase
    endfunction : is_mem_dest

    function automatic logic [1:0] base_cycles(input mieu_pkg::mieu_op_e op);
        case (op)
            mieu_pkg::OP_JMP, mieu_pkg::OP_CALL, mieu_pkg::OP_RET,
            mieu_pkg::OP_INTERRUPT_RETURN, mieu_pkg::OP_RETA, mieu_pkg::OP_TRDC,
            mieu_pkg::OP_TRDL: base_cycles = mieu_pkg::BASE_TWO;
            default: base_cycles = mieu_pkg::BASE_ONE;
        endcase
    endfunction : base_cycles

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] m;
    logic [7:0] a;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic res_acc;
    logic do_skip;
    logic [2:0] extra;
    logic take;
    logic [7:0] opb;

    always_comb begin
        // [RQ21] flags hold unless written
        s_d = s_q;
        m = i_mem_rdata;
        a = s_q.acc;
        sum9 = 9'h000;
        sum5 = 5'h00;
        res = 8'h00;
        res_acc = 1'b0;
        do_skip = 1'b0;
        extra = 3'h0;
        opb = 8'h00;
        take = i_issue && (s_q.st == mieu_pkg::ST_IDLE);
        s_d.we = 1'b0;
        s_d.skip = 1'b0;
        if (s_q.st == mieu_pkg::ST_BUSY) begin
            s_d.phase = s_q.phase + 2'h1;
            if (s_q.phase == mieu_pkg::PHASE_LAST) begin
                if (s_q.left == 2'h1) begin
                    s_d.st = mieu_pkg::ST_IDLE;
                end
                s_d.left = s_q.left - 2'h1;
            end
        end
        if (take) begin
            s_d.addr = i_instr.mem;
            case (i_instr.op)
                // [RQ8] plain add
                mieu_pkg::OP_ADD, mieu_pkg::OP_SUM_TO_MEMORY: begin
                    sum9 = {1'b0, a} + {1'b0, m};
                    opb = m;
                    sum5 = {1'b0, a[3:0]} + {1'b0, m[3:0]};
                end
                mieu_pkg::OP_ADDI: begin
                    sum9 = {1'b0, a} + {1'b0, i_instr.imm};
                    opb = i_instr.imm;
                    sum5 = {1'b0, a[3:0]} + {1'b0, i_instr.imm[3:0]};
                end
                // [RQ7] add with carry
                mieu_pkg::OP_ADC, mieu_pkg::OP_SUM_WITH_CARRY_TO_MEMORY: begin
                    sum9 = {1'b0, a} + {1'b0, m} + {8'h00, s_q.fl.carry_flag};
                    opb = m;
                    sum5 = {1'b0, a[3:0]} + {1'b0, m[3:0]}
                        + {4'h0, s_q.fl.carry_flag};
                end
                mieu_pkg::OP_SUB, mieu_pkg::OP_SUBM: begin
                    sum9 = {1'b0, a} + {1'b0, ~m} + 9'h001;
                    opb = ~m;
                    sum5 = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
                end
                mieu_pkg::OP_SUBI: begin
                    sum9 = {1'b0, a} + {1'b0, ~i_instr.imm} + 9'h001;
                    opb = ~i_instr.imm;
                    sum5 = {1'b0, a[3:0]} + {1'b0, ~i_instr.imm[3:0]} + 5'h01;
                end
                // [RQ10] subtract with borrow
                mieu_pkg::OP_SBC, mieu_pkg::OP_SBCM: begin
                    sum9 = {1'b0, a} + {1'b0, ~m} + {8'h00, s_q.fl.carry_flag};
                    opb = ~m;
                    sum5 = {1'b0, a[3:0]} + {1'b0, ~m[3:0]}
                        + {4'h0, s_q.fl.carry_flag};
                end
                default: begin
                    sum9 = 9'h000;
                end
            endcase
            case (i_instr.op)
                // [RQ9] arithmetic flags
                mieu_pkg::OP_ADD, mieu_pkg::OP_SUM_TO_MEMORY, mieu_pkg::OP_ADDI,
                mieu_pkg::OP_ADC, mieu_pkg::OP_SUM_WITH_CARRY_TO_MEMORY, mieu_pkg::OP_SUB,
                mieu_pkg::OP_SUBM, mieu_pkg::OP_SUBI, mieu_pkg::OP_SBC,
                mieu_pkg::OP_SBCM: begin
                    res = sum9[7:0];
                    res_acc = !is_mem_dest(i_instr.op);
                    s_d.fl.carry_flag = sum9[8];
                    s_d.fl.half_carry_flag = sum5[4];
                    s_d.fl.zero_flag = (sum9[7:0] == 8'h00);
                    s_d.fl.signed_result_flag = (a[7] == opb[7])
                        && (res[7] != a[7]);
                end
                // [RQ11] decimal adjust, carry only
                mieu_pkg::OP_DAA: begin
                    sum9 = {1'b0, a};
                    if (a[3:0] > 4'h9 || s_q.fl.half_carry_flag) begin
                        sum9 = sum9 + 9'h006;
                    end
                    if (sum9[7:4] > 4'h9 || sum9[8] || s_q.fl.carry_flag) begin
                        sum9 = sum9 + 9'h060;
                    end
                    res = sum9[7:0];
                    s_d.fl.carry_flag = sum9[8] | s_q.fl.carry_flag;
                end
                // [RQ12] logic ops, zero only
                mieu_pkg::OP_AND, mieu_pkg::OP_ANDM: res = a & m;
                mieu_pkg::OP_OR, mieu_pkg::OP_ORM: res = a | m;
                mieu_pkg::OP_XOR, mieu_pkg::OP_XORM: res = a ^ m;
                mieu_pkg::OP_ANDI: res = a & i_instr.imm;
                mieu_pkg::OP_ORI: res = a | i_instr.imm;
                mieu_pkg::OP_XORI: res = a ^ i_instr.imm;
                // [RQ13] complement to either destination
                mieu_pkg::OP_CPL, mieu_pkg::OP_CPLA: res = ~m;
                mieu_pkg::OP_INC, mieu_pkg::OP_INCA, mieu_pkg::OP_SIZ,
                mieu_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR: res = m + 8'h01;
                mieu_pkg::OP_DEC, mieu_pkg::OP_DECA, mieu_pkg::OP_SDZ,
                mieu_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR: res = m - 8'h01;
                // [RQ14] rotates
                mieu_pkg::OP_RR, mieu_pkg::OP_RRA: res = {m[0], m[7:1]};
                mieu_pkg::OP_RL, mieu_pkg::OP_RLA: res = {m[6:0], m[7]};
                mieu_pkg::OP_RRC, mieu_pkg::OP_RRCA: begin
                    res = {s_q.fl.carry_flag, m[7:1]};
                    s_d.fl.carry_flag = m[0];
                end
                mieu_pkg::OP_RLC, mieu_pkg::OP_RLCA: begin
                    res = {m[6:0], s_q.fl.carry_flag};
                    s_d.fl.carry_flag = m[7];
                end
                // [RQ15] moves
                mieu_pkg::OP_MOVA, mieu_pkg::OP_SZA: res = m;
                mieu_pkg::OP_MOVM: res = a;
                mieu_pkg::OP_MOVI, mieu_pkg::OP_RETA: res = i_instr.imm;
                // [RQ16] bit set and clear
                mieu_pkg::OP_BCLR: begin
                    res = m & ~(8'h01 << i_instr.bit_idx);
                end
                mieu_pkg::OP_BSET: res = m | (8'h01 << i_instr.bit_idx);
                // [RQ6] table reads
                mieu_pkg::OP_TRDC, mieu_pkg::OP_TRDL: begin
                    res = i_instr.rom_word[7:0];
                    s_d.table_high_byte = i_instr.rom_word[15:8];
                end
                mieu_pkg::OP_CLRM: res = 8'h00;
                mieu_pkg::OP_SETM: res = 8'hFF;
                // [RQ19] nibble swap
                mieu_pkg::OP_SWAP, mieu_pkg::OP_SWAPA: res = {m[3:0], m[7:4]};
                mieu_pkg::OP_CLRWDT: begin
                    s_d.fl.watchdog_expiry_flag = 1'b0;
                    s_d.fl.power_down_flag = 1'b0;
                end
                // [RQ4] preclear pair
                mieu_pkg::OP_WDTP1, mieu_pkg::OP_WDTP2: begin
                    if (i_instr.wdt_pair_done) begin
                        s_d.fl.watchdog_expiry_flag = 1'b0;
                        s_d.fl.power_down_flag = 1'b0;
                    end
                end
                // [RQ20] halt
                mieu_pkg::OP_HALT: begin
                    s_d.pd = 1'b1;
                    s_d.fl.watchdog_expiry_flag = 1'b0;
                    s_d.fl.power_down_flag = 1'b1;
                end
                default: res = 8'h00;
            endcase
            case (i_instr.op)
                mieu_pkg::OP_AND, mieu_pkg::OP_OR, mieu_pkg::OP_XOR,
                mieu_pkg::OP_ANDM, mieu_pkg::OP_ORM, mieu_pkg::OP_XORM,
                mieu_pkg::OP_ANDI, mieu_pkg::OP_ORI, mieu_pkg::OP_XORI,
                mieu_pkg::OP_CPL, mieu_pkg::OP_CPLA, mieu_pkg::OP_INC,
                mieu_pkg::OP_INCA, mieu_pkg::OP_DEC, mieu_pkg::OP_DECA: begin
                    s_d.fl.zero_flag = (res == 8'h00);
                    res_acc = !is_mem_dest(i_instr.op);
                end
                mieu_pkg::OP_RRA, mieu_pkg::OP_RLA, mieu_pkg::OP_RRCA,
                mieu_pkg::OP_RLCA, mieu_pkg::OP_MOVA, mieu_pkg::OP_MOVI,
                mieu_pkg::OP_SZA, mieu_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR, mieu_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR,
                mieu_pkg::OP_SWAPA, mieu_pkg::OP_RETA: res_acc = 1'b1;
                default: res_acc = res_acc;
            endcase
            // [RQ17] skip decisions
            case (i_instr.op)
                mieu_pkg::OP_SZ, mieu_pkg::OP_SZA: do_skip = (m == 8'h00);
                mieu_pkg::OP_SZB: do_skip = !m[i_instr.bit_idx];
                mieu_pkg::OP_SNZB: do_skip = m[i_instr.bit_idx];
                mieu_pkg::OP_SIZ, mieu_pkg::OP_SDZ, mieu_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR,
                mieu_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR: do_skip = (res == 8'h00);
                default: do_skip = 1'b0;
            endcase
            if (res_acc) begin
                s_d.acc = res;
            end
            s_d.we = is_mem_dest(i_instr.op);
            s_d.wdata = res;
            // [RQ1] [RQ3] [RQ18] program counter low byte penalty
            if (is_mem_dest(i_instr.op) && i_instr.pcl_target) begin
                extra = extra + 3'h1;
            end
            // [RQ2] skip penalty
            if (do_skip) begin
                extra = extra + 3'h1;
            end
            // [RQ5] fixed two-cycle flow control
            s_d.cycles = {1'b0, base_cycles(i_instr.op)} + extra;
            s_d.left = 2'(s_d.cycles);
            s_d.skip = do_skip;
            s_d.phase = 2'h0;
            s_d.st = mieu_pkg::ST_BUSY;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '{st: mieu_pkg::ST_IDLE, phase: 2'h0, left: 2'h0,
                cycles: 3'h0, acc: mieu_pkg::RST_ACC,
                table_high_byte: mieu_pkg::RST_TABLE_HIGH_BYTE, fl: mieu_pkg::RST_FLAGS, pd: 1'b0,
                we: 1'b0, addr: 8'h00, wdata: 8'h00, skip: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_ready = (s_q.st == mieu_pkg::ST_IDLE);
    assign o_mem_we = s_q.we;
    assign o_mem_addr = s_q.addr;
    assign o_mem_wdata = s_q.wdata;
    assign o_acc = s_q.acc;
    assign o_table_high_byte = s_q.table_high_byte;
    assign o_flags = s_q.fl;
    assign o_power_down = s_q.pd;
    assign o_skip = s_q.skip;
    assign o_cycles = s_q.cycles;

    ////////////////////////////////////////////////////////////////////////
    // [RQ21] flags held on jump, call, no-op and move to accumulator
    flags_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_JMP, mieu_pkg::OP_CALL,
        mieu_pkg::OP_NOP, mieu_pkg::OP_MOVA} |=> o_flags == $past(o_flags))
        else $error("flags changed by flag-neutral op"); // [RQ21]
    // [RQ5] two cycles
    flow_two_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op == mieu_pkg::OP_RET |=> o_cycles == 3'h2)
        else $error("return not two cycles"); // [RQ5]
    // [RQ1] pcl penalty
    pcl_extra_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_MOVM, mieu_pkg::OP_SUM_TO_MEMORY}
        && i_instr.pcl_target
        |=> o_cycles == 3'h2 ##1 !o_ready [*7] ##1 o_ready)
        else $error("pcl write not extended"); // [RQ1]
    // [RQ3] both penalties
    siz_both_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.pcl_target && (i_instr.op == mieu_pkg::OP_SIZ
        && i_mem_rdata == 8'hFF || i_instr.op == mieu_pkg::OP_SDZ
        && i_mem_rdata == 8'h01) |=> o_cycles == 3'h3 && o_skip)
        else $error("double penalty missing"); // [RQ3]
    // [RQ18] accumulator skip only skip penalty
    increment_skip_to_accumulator_one_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR, mieu_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR}
        && i_instr.pcl_target
        |=> o_cycles == {2'h0, o_skip} + 3'h1 && !o_mem_we)
        else $error("accumulator skip penalised"); // [RQ18]
    // [RQ4] preclear holds flags when not paired
    wdt_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op == mieu_pkg::OP_WDTP1 && !i_instr.wdt_pair_done
        |=> o_flags == $past(o_flags))
        else $error("preclear changed flags"); // [RQ4]
    // [RQ20] halt
    halt_pd_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op == mieu_pkg::OP_HALT
        |=> o_power_down && o_flags.power_down_flag)
        else $error("halt missed power-down"); // [RQ20]
    // [RQ7] add with carry result
    adc_sum_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op == mieu_pkg::OP_ADC |=> o_acc == 8'($past(o_acc)
        + $past(i_mem_rdata) + {7'h00, $past(o_flags.carry_flag)}))
        else $error("add with carry wrong"); // [RQ7]
    // [RQ14] plain rotate keeps carry
    rot_plain_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_RR, mieu_pkg::OP_RRA}
        |=> o_flags == $past(o_flags))
        else $error("plain rotate changed flag"); // [RQ14]
    // [RQ12] logic ops touch zero only
    logic_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_ANDI, mieu_pkg::OP_CPLA}
        |=> (o_flags & 6'h3B) == ($past(o_flags) & 6'h3B))
        else $error("logic op changed a non-zero flag"); // [RQ12]
    // [RQ9] arithmetic single cycle
    arith_one_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        take && i_instr.op inside {mieu_pkg::OP_ADD, mieu_pkg::OP_SUB,
        mieu_pkg::OP_SBCM} && !i_instr.pcl_target |=> o_cycles == 3'h1)
        else $error("arithmetic not one cycle"); // [RQ9]

    skip_c: cover property (@(posedge i_core_clk) o_skip);
    halt_c: cover property (@(posedge i_core_clk) o_power_down);
    three_c: cover property (@(posedge i_core_clk) o_cycles == 3'h3);
    write_c: cover property (@(posedge i_core_clk) o_mem_we && o_skip);
    table_c: cover property (@(posedge i_core_clk) o_table_high_byte != 8'h00);
endmodule : mieu_core
`default_nettype wire

// [hw/mieu_pkg.sv]
package mieu_pkg;
    // instruction classes presented by the fetch stage
    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_ADD = 6'h01, OP_SUM_TO_MEMORY = 6'h02, OP_ADDI = 6'h03,
        OP_ADC = 6'h04, OP_SUM_WITH_CARRY_TO_MEMORY = 6'h05, OP_SUB = 6'h06, OP_SUBI = 6'h07,
        OP_SUBM = 6'h08, OP_SBC = 6'h09, OP_SBCM = 6'h0A, OP_DAA = 6'h0B,
        OP_AND = 6'h0C, OP_OR = 6'h0D, OP_XOR = 6'h0E, OP_ANDM = 6'h0F,
        OP_ORM = 6'h10, OP_XORM = 6'h11, OP_ANDI = 6'h12, OP_ORI = 6'h13,
        OP_XORI = 6'h14, OP_CPL = 6'h15, OP_CPLA = 6'h16, OP_INCA = 6'h17,
        OP_INC = 6'h18, OP_DECA = 6'h19, OP_DEC = 6'h1A, OP_RRA = 6'h1B,
        OP_RR = 6'h1C, OP_RRCA = 6'h1D, OP_RRC = 6'h1E, OP_RLA = 6'h1F,
        OP_RL = 6'h20, OP_RLCA = 6'h21, OP_RLC = 6'h22, OP_MOVA = 6'h23,
        OP_MOVM = 6'h24, OP_MOVI = 6'h25, OP_BCLR = 6'h26, OP_BSET = 6'h27,
        OP_JMP = 6'h28, OP_SZ = 6'h29, OP_SZA = 6'h2A, OP_SZB = 6'h2B,
        OP_SNZB = 6'h2C, OP_SIZ = 6'h2D, OP_SDZ = 6'h2E, OP_INCREMENT_SKIP_TO_ACCUMULATOR = 6'h2F,
        OP_DECREMENT_SKIP_TO_ACCUMULATOR = 6'h30, OP_CALL = 6'h31, OP_RET = 6'h32, OP_INTERRUPT_RETURN = 6'h33,
        OP_RETA = 6'h34, OP_TRDC = 6'h35, OP_TRDL = 6'h36, OP_CLRM = 6'h37,
        OP_SETM = 6'h38, OP_CLRWDT = 6'h39, OP_WDTP1 = 6'h3A,
        OP_WDTP2 = 6'h3B, OP_SWAP = 6'h3C, OP_SWAPA = 6'h3D, OP_HALT = 6'h3E
    } mieu_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01
    } mieu_state_e;

    // issued instruction
    typedef struct packed {
        mieu_op_e op;
        logic [7:0] mem;
        logic [7:0] imm;
        logic [2:0] bit_idx;
        logic pcl_target;
        logic wdt_pair_done;
        logic [15:0] rom_word;
    } mieu_instr_s;

    // status flags
    typedef struct packed {
        logic watchdog_expiry_flag;
        logic power_down_flag;
        logic signed_result_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } mieu_flags_s;

    localparam logic [2:0] SYS_PER_CYCLE = 3'h4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] BASE_ONE = 2'h1;
    localparam logic [1:0] BASE_TWO = 2'h2;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_TABLE_HIGH_BYTE = 8'h00;
    localparam mieu_flags_s RST_FLAGS = '0;
endpackage : mieu_pkg
